// ===== src/cod_pkg.sv
`default_nettype none
package cod_pkg;
	// Object indices.
	localparam logic [15:0] IDX_DEVTYPE = 16'h1000;
	localparam logic [15:0] IDX_FAULT   = 16'h1001;
	localparam logic [15:0] IDX_HIST    = 16'h1003;
	localparam logic [15:0] IDX_SYNC    = 16'h1005;
	localparam logic [15:0] IDX_GUARD   = 16'h100C;
	localparam logic [15:0] IDX_LIFE    = 16'h100D;
	localparam logic [15:0] IDX_STORE   = 16'h1010;
	localparam logic [15:0] IDX_RESTORE = 16'h1011;
	localparam logic [15:0] IDX_ALARM   = 16'h1014;
	localparam logic [15:0] IDX_CONSHB  = 16'h1016;
	localparam logic [15:0] IDX_PRODHB  = 16'h1017;
	localparam logic [15:0] IDX_OPX     = 16'h6011;
	localparam logic [15:0] IDX_OPY     = 16'h6021;
	// Signatures, least significant byte first on the wire.
	localparam logic [31:0] SIG_SAVE = 32'h65766173;
	localparam logic [31:0] SIG_LOAD = 32'h64616F6C;
	// Values after reset.
	localparam logic [31:0] DEVTYPE_DUAL   = 32'h0002019A;
	localparam logic [31:0] DEVTYPE_SINGLE = 32'h0001019A;
	localparam logic [31:0] SYNC_RST       = 32'h00000080;
	localparam logic [31:0] ALARM_RST      = 32'h00000081;
	localparam logic [7:0]  GROUP_COUNT    = 8'h04;
	localparam logic [7:0]  CONSHB_COUNT   = 8'h01;
	// Operating parameter bits.
	localparam int OP_INV_BIT   = 0;
	localparam int OP_SCALE_BIT = 1;
	// Frame identifier bases.
	localparam logic [10:0] PDO_BASE = 11'h180;
	localparam logic [10:0] HB_BASE  = 11'h700;
	// One millisecond in clock cycles at 125 MHz.
	localparam int MS_NS      = 1000000;
	localparam int CLK_NS     = 8;
	localparam int CYC_PER_MS = MS_NS / CLK_NS;
	// Object access request and answer.
	typedef struct packed {
		logic        valid;
		logic        wr;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} cod_req_type;
	typedef struct packed {
		logic        ack;
		logic        abort;
		logic [31:0] rdata;
	} cod_rsp_type;
	// A frame identifier with its strobe.
	typedef struct packed {
		logic        valid;
		logic [10:0] id;
	} cod_frame_type;
	// Power-up reconciliation states.
	typedef enum logic [0:0] {PU_LOAD = 1'b0, PU_RUN = 1'b1} cod_pu_type;
endpackage
`default_nettype wire

// ===== src/cod_core.sv
`timescale 1ns/1ps
`default_nettype none
module cod_core import cod_pkg::*; #(
	parameter int          DUAL_AXIS  = 1,
	parameter int          HIST_DEPTH = 4,
	parameter int          CYC_MS     = CYC_PER_MS,
	parameter logic [10:0] NODE_ID    = 11'h001
) (
	// Clock, reset and freeze.
	input  wire logic          ref_clk,
	input  wire logic          arst_n,
	input  wire logic          clk_en,
	// Object access.
	input  wire cod_req_type   od_req,
	output cod_rsp_type        od_rsp,
	// Received frames and node state.
	input  wire cod_frame_type rx_frame,
	input  wire logic          operational,
	// Transmit arbitration.
	output cod_frame_type      tx_frame,
	output logic               tx_is_alarm,
	input  wire logic          tx_ready,
	// Fault reporting.
	input  wire logic          fault_active,
	input  wire logic          fault_event,
	input  wire logic [31:0]   fault_info,
	// Position path.
	input  wire logic [15:0]   raw_long,
	input  wire logic [15:0]   raw_trans,
	input  wire logic [15:0]   offset_long,
	input  wire logic [15:0]   offset_trans,
	output logic [15:0]        longitudinal_tilt_short,
	output logic [15:0]        transverse_tilt_short,
	output logic [31:0]        longitudinal_tilt_wide,
	output logic [31:0]        transverse_tilt_wide,
	// Stored values seen at power-up.
	input  wire logic [15:0]   nv_cyclic,
	input  wire logic [15:0]   nv_evt1,
	input  wire logic [15:0]   nv_evt2,
	input  wire logic [15:0]   nv_preset_x,
	input  wire logic [15:0]   nv_preset_y,
	input  wire logic [15:0]   nv_app_x,
	input  wire logic [15:0]   nv_app_y,
	output logic [15:0]        cyclic_interval,
	output logic [15:0]        preset_x,
	output logic [15:0]        preset_y,
	// Non-volatile store and restore.
	output logic               nv_store_pulse,
	output logic [3:0]         nv_store_group,
	output logic [3:0]         restore_armed,
	// Supervision.
	output logic [23:0]        life_time_ms,
	output logic               hb_lost
);
	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) rst_sync_reg <= 2'b00;
		else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Register storage.
	logic [31:0] sync_reg, alarm_reg, conshb_reg;
	logic [15:0] guard_reg, prodhb_reg;
	logic [7:0]  life_reg, hist_cnt_reg;
	logic [15:0] op_reg [2];
	logic [31:0] hist_reg [HIST_DEPTH];
	logic [3:0]  restore_reg;
	cod_rsp_type rsp_reg;

	// Request decode.
	logic wr, rd, s0, s1, s14;
	assign wr  = od_req.valid & od_req.wr;
	assign rd  = od_req.valid & ~od_req.wr;
	assign s0  = (od_req.sub == 8'h00);
	assign s1  = (od_req.sub == 8'h01);
	assign s14 = (od_req.sub >= 8'h01) && (od_req.sub <= 8'h04);
	logic i_dev, i_flt, i_hist, i_sync, i_grd, i_life, i_st, i_rs;
	logic i_alm, i_chb, i_phb, i_opx, i_opy;
	assign i_dev  = od_req.index == IDX_DEVTYPE;
	assign i_flt  = od_req.index == IDX_FAULT;
	assign i_hist = od_req.index == IDX_HIST;
	assign i_sync = od_req.index == IDX_SYNC;
	assign i_grd  = od_req.index == IDX_GUARD;
	assign i_life = od_req.index == IDX_LIFE;
	assign i_st   = od_req.index == IDX_STORE;
	assign i_rs   = od_req.index == IDX_RESTORE;
	assign i_alm  = od_req.index == IDX_ALARM;
	assign i_chb  = od_req.index == IDX_CONSHB;
	assign i_phb  = od_req.index == IDX_PRODHB;
	assign i_opx  = od_req.index == IDX_OPX;
	assign i_opy  = od_req.index == IDX_OPY;

	// Write strobes; the read-only device type never appears here.
	logic w_hclr, w_sync, w_grd, w_life, w_alm, w_chb, w_phb, w_opx, w_opy;
	logic w_store, w_rest, w_bad;
	assign w_hclr  = wr & i_hist & s0 & (od_req.wdata == 32'h0);
	assign w_sync  = wr & i_sync & s0;
	assign w_grd   = wr & i_grd & s0;
	assign w_life  = wr & i_life & s0;
	assign w_alm   = wr & i_alm & s0;
	assign w_chb   = wr & i_chb & s1;
	assign w_phb   = wr & i_phb & s0;
	assign w_opx   = wr & i_opx & s0;
	assign w_opy   = wr & i_opy & s0;
	assign w_store = wr & i_st & s14 & (od_req.wdata == SIG_SAVE);
	assign w_rest  = wr & i_rs & s14 & (od_req.wdata == SIG_LOAD);
	// Any other write, including a wrong signature, is refused.
	assign w_bad = wr & ~(w_hclr | w_sync | w_grd | w_life | w_alm | w_chb
		| w_phb | w_opx | w_opy | w_store | w_rest);

	// Read selection, an AND-OR of every readable object.
	logic [31:0] devtype, hist_sel, rdata;
	logic        rd_ok;
	logic [7:0]  hsub;
	assign devtype = (DUAL_AXIS != 0) ? DEVTYPE_DUAL : DEVTYPE_SINGLE;
	assign hsub    = od_req.sub - 8'h01;
	assign hist_sel = (od_req.sub != 8'h00 && od_req.sub <= 8'(HIST_DEPTH))
		? hist_reg[hsub[$clog2(HIST_DEPTH)-1:0]] : 32'h0;
	assign rdata =
		({32{i_dev & s0}} & devtype)
		| ({32{i_flt & s0}} & {31'h0, fault_active})
		| ({32{i_hist & s0}} & {24'h0, hist_cnt_reg})
		| ({32{i_hist & ~s0}} & hist_sel)
		| ({32{i_sync & s0}} & sync_reg)
		| ({32{i_grd & s0}} & {16'h0, guard_reg})
		| ({32{i_life & s0}} & {24'h0, life_reg})
		| ({32{(i_st | i_rs) & s0}} & {24'h0, GROUP_COUNT})
		| ({32{(i_st | i_rs) & s14}} & 32'h00000001)
		| ({32{i_alm & s0}} & alarm_reg)
		| ({32{i_chb & s0}} & {24'h0, CONSHB_COUNT})
		| ({32{i_chb & s1}} & conshb_reg)
		| ({32{i_phb & s0}} & {16'h0, prodhb_reg})
		| ({32{i_opx & s0}} & {16'h0, op_reg[0]})
		| ({32{i_opy & s0}} & {16'h0, op_reg[1]});
	// History entries beyond the current count are refused as unmapped.
	assign rd_ok = s0 & (i_dev | i_flt | i_hist | i_sync | i_grd | i_life
		| i_st | i_rs | i_alm | i_chb | i_phb | i_opx | i_opy)
		| (i_hist & ~s0 & (od_req.sub <= hist_cnt_reg))
		| ((i_st | i_rs) & s14) | (i_chb & s1);

	// Answer one cycle after the request.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) rsp_reg <= '0;
		else if (clk_en) begin
			rsp_reg.ack   <= od_req.valid;
			rsp_reg.abort <= w_bad | (rd & ~rd_ok);
			rsp_reg.rdata <= (rd & rd_ok) ? rdata : 32'h0;
		end
	end
	assign od_rsp = rsp_reg;

	////////////////////////////////////////////////////////////////////////
	// Plain read-write objects.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg   <= SYNC_RST;
			alarm_reg  <= ALARM_RST;
			guard_reg  <= 16'h0000;
			life_reg   <= 8'h00;
			conshb_reg <= 32'h0;
			prodhb_reg <= 16'h0000;
			op_reg[0]  <= 16'h0000;
			op_reg[1]  <= 16'h0000;
		end else if (clk_en) begin
			if (w_sync) sync_reg <= od_req.wdata;
			if (w_alm)  alarm_reg <= od_req.wdata;
			if (w_grd)  guard_reg <= od_req.wdata[15:0];
			if (w_life) life_reg <= od_req.wdata[7:0];
			if (w_chb)  conshb_reg <= {8'h00, od_req.wdata[23:0]};
			if (w_phb)  prodhb_reg <= od_req.wdata[15:0];
			if (w_opx)  op_reg[0] <= od_req.wdata[15:0];
			if (w_opy)  op_reg[1] <= od_req.wdata[15:0];
		end
	end
	assign life_time_ms = 24'(guard_reg) * 24'(life_reg);

	////////////////////////////////////////////////////////////////////////
	// Error history: newest at entry 0; a fault in the clearing cycle wins.
	logic [7:0] cnt_next;
	assign cnt_next = w_hclr ? (fault_event ? 8'h01 : 8'h00)
		: (fault_event && hist_cnt_reg < 8'(HIST_DEPTH))
		? hist_cnt_reg + 8'h01 : hist_cnt_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) hist_cnt_reg <= 8'h00;
		else if (clk_en) hist_cnt_reg <= cnt_next;
	end
	genvar g;
	generate
		for (g = 0; g < HIST_DEPTH; g++) begin : g_hist
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) hist_reg[g] <= 32'h0;
				else if (clk_en && fault_event) begin
					hist_reg[g] <= (g == 0) ? fault_info : hist_reg[(g == 0) ? 0 : g-1];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Position scaling and inversion, one stage per axis.
	logic [15:0] raw [2];
	logic [15:0] off [2];
	logic [15:0] tilt_reg [2];
	assign raw[0] = raw_long;
	assign raw[1] = raw_trans;
	assign off[0] = offset_long;
	assign off[1] = offset_trans;
	generate
		for (g = 0; g < 2; g++) begin : g_axis
			logic [15:0] neg, base, res;
			assign neg  = 16'(17'h10000 - {1'b0, raw[g]});
			assign base = op_reg[g][OP_INV_BIT] ? neg : raw[g];
			assign res  = op_reg[g][OP_SCALE_BIT] ? base + off[g] : base;
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) tilt_reg[g] <= 16'h0000;
				else if (clk_en) tilt_reg[g] <= res;
			end
		end
	endgenerate
	// Integer counts only; the resolution sets what one count means.
	assign longitudinal_tilt_short = tilt_reg[0];
	assign transverse_tilt_short   = tilt_reg[1];
	assign longitudinal_tilt_wide  = {{16{tilt_reg[0][15]}}, tilt_reg[0]};
	assign transverse_tilt_wide    = {{16{tilt_reg[1][15]}}, tilt_reg[1]};

	////////////////////////////////////////////////////////////////////////
	// Power-up reconciliation, taken once just after the reset release.
	cod_pu_type  pu_reg;
	logic [15:0] cyc_reg, px_reg, py_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pu_reg  <= PU_LOAD;
			cyc_reg <= 16'h0000;
			px_reg  <= 16'h0000;
			py_reg  <= 16'h0000;
		end else if (clk_en) begin
			unique case (pu_reg)
				PU_LOAD: begin
					cyc_reg <= (nv_cyclic != nv_evt1 || nv_cyclic != nv_evt2)
						? nv_evt1 : nv_cyclic;
					px_reg  <= (nv_preset_x != nv_app_x) ? nv_app_x : nv_preset_x;
					py_reg  <= (nv_preset_y != nv_app_y) ? nv_app_y : nv_preset_y;
					pu_reg  <= PU_RUN;
				end
				PU_RUN: pu_reg <= PU_RUN;
			endcase
		end
	end
	assign cyclic_interval = cyc_reg;
	assign preset_x        = px_reg;
	assign preset_y        = py_reg;

	////////////////////////////////////////////////////////////////////////
	// Store pulses and restore arming. The restore only marks groups; the
	// loader applies them after the next power cycle and never touches the
	// bit rate, node number, termination or boot-up settings.
	logic       st_pulse_reg;
	logic [3:0] st_grp_reg, sel;
	assign sel = 4'(4'h1 << (od_req.sub[1:0] - 2'b01)); // Sub 1 to 4 map to bits 0 to 3.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_pulse_reg <= 1'b0;
			st_grp_reg   <= 4'h0;
			restore_reg  <= 4'h0;
		end else if (clk_en) begin
			st_pulse_reg <= w_store;
			st_grp_reg   <= w_store ? sel : 4'h0;
			if (w_rest) restore_reg <= restore_reg | sel;
		end
	end
	assign nv_store_pulse = st_pulse_reg;
	assign nv_store_group = st_grp_reg;
	assign restore_armed  = restore_reg;

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick and heartbeat supervision.
	logic [$clog2(CYC_MS)-1:0] ms_cnt_reg;
	logic [15:0] cons_cnt_reg, prod_cnt_reg;
	logic        ms_tick, lost_reg, hb_seen, sync_hit, prod_tick;
	assign ms_tick  = (ms_cnt_reg == ($clog2(CYC_MS))'(CYC_MS - 1));
	assign hb_seen  = rx_frame.valid && rx_frame.id == HB_BASE + {3'b000, conshb_reg[23:16]};
	assign sync_hit = rx_frame.valid && operational && rx_frame.id == sync_reg[10:0];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_reg   <= '0;
			cons_cnt_reg <= 16'h0000;
			prod_cnt_reg <= 16'h0000;
			lost_reg     <= 1'b0;
		end else if (clk_en) begin
			ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + ($clog2(CYC_MS))'(1);
			// Only one node is watched; a zero time stops it.
			if (conshb_reg[15:0] == 16'h0000 || hb_seen) begin
				cons_cnt_reg <= 16'h0000;
				lost_reg     <= 1'b0;
			end else if (ms_tick) begin
				if (cons_cnt_reg + 16'h0001 >= conshb_reg[15:0]) lost_reg <= 1'b1;
				else cons_cnt_reg <= cons_cnt_reg + 16'h0001;
			end
			if (prodhb_reg == 16'h0000 || prod_tick) prod_cnt_reg <= 16'h0000;
			else if (ms_tick) prod_cnt_reg <= prod_cnt_reg + 16'h0001;
		end
	end
	assign prod_tick = ms_tick && prodhb_reg != 16'h0000
		&& prod_cnt_reg + 16'h0001 >= prodhb_reg;
	assign hb_lost = lost_reg;

	////////////////////////////////////////////////////////////////////////
	// Transmit requests: alarm first, then process data, then heartbeat.
	logic alm_pend_reg, pdo_pend_reg, hb_pend_reg, take;
	assign take        = tx_frame.valid & tx_ready;
	assign tx_is_alarm = alm_pend_reg;
	assign tx_frame.valid = alm_pend_reg | pdo_pend_reg | hb_pend_reg;
	assign tx_frame.id = alm_pend_reg ? alarm_reg[10:0]
		: pdo_pend_reg ? PDO_BASE + NODE_ID : HB_BASE + NODE_ID;
	// A new event in the sending cycle keeps its flag set.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alm_pend_reg <= 1'b0;
			pdo_pend_reg <= 1'b0;
			hb_pend_reg  <= 1'b0;
		end else if (clk_en) begin
			alm_pend_reg <= fault_event | (alm_pend_reg & ~take);
			pdo_pend_reg <= sync_hit | (pdo_pend_reg & ~(take & ~alm_pend_reg));
			hb_pend_reg  <= prod_tick | (hb_pend_reg & ~(take & ~alm_pend_reg & ~pdo_pend_reg));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_INVERT: assert property (clk_en && op_reg[0] == 16'h0001 |=> !clk_en
		|| longitudinal_tilt_short == 16'(17'h10000 - {1'b0, $past(raw_long)}))
		else $error("inverted tilt wrong");
	AST_SCALE: assert property (clk_en && op_reg[1] == 16'h0002 |=> !clk_en
		|| transverse_tilt_short == $past(raw_trans) + $past(offset_trans))
		else $error("scaled tilt wrong");
	AST_BOTH: assert property (clk_en && op_reg[0] == 16'h0003 |=> !clk_en
		|| longitudinal_tilt_short == 16'(16'h0 - $past(raw_long)) + $past(offset_long))
		else $error("inverted scaled tilt wrong");
	AST_SYNC: assert property (clk_en && sync_hit |=> pdo_pend_reg)
		else $error("sync not answered");
	AST_STORE: assert property (clk_en && w_store |=> nv_store_pulse && nv_store_group != 4'h0)
		else $error("store missing");
	AST_BADSIG: assert property (clk_en && wr && i_st && od_req.wdata != SIG_SAVE
		|=> !nv_store_pulse && od_rsp.abort) else $error("bad signature taken");
	AST_CLEAR: assert property (clk_en && w_hclr && !fault_event |=> hist_cnt_reg == 8'h00)
		else $error("log not cleared");
	AST_ALARM_FIRST: assert property (clk_en && alm_pend_reg && pdo_pend_reg && take
		|-> tx_frame.id == alarm_reg[10:0] ##1 pdo_pend_reg) else $error("alarm lost priority");
	AST_LIFE: assert property (life_time_ms == 24'(guard_reg * life_reg))
		else $error("life time wrong");
	AST_HB_OFF: assert property (clk_en && conshb_reg[15:0] == 16'h0000 |=> !hb_lost)
		else $error("supervision active at zero");
	COV_SYNC: cover property (sync_hit ##1 take);
	COV_ALARM_PDO: cover property (alm_pend_reg && pdo_pend_reg);
	COV_RESTORE: cover property (w_rest);
endmodule // cod_core
`default_nettype wire

// ===== tb/cod_master.sv
`timescale 1ns/1ps
`default_nettype none
// Network master model: issues one object access at a time on the falling edge.
module cod_master import cod_pkg::*; (
	// Clock.
	input  wire logic         ref_clk,
	// Object access.
	output var cod_req_type   od_req,
	input  wire cod_rsp_type  od_rsp
);
	initial od_req = '0;
	////////////////////////////////////////////////////////////////////////////////
	// One access; idle fields carry inverted values so nothing stale can match.
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
		output logic [31:0] rd, output logic ab);
		int n;
		@(negedge ref_clk);
		od_req <= '{1'b1, w, i, s, d};
		@(negedge ref_clk);
		// The request was taken at the edge just passed; its answer stands until the next edge.
		od_req <= '{1'b0, ~w, ~i, ~s, ~d};
		rd = 32'hFFFFFFFF;
		ab = 1'b1;
		for (n = 0; n < 8; n++) begin
			if (od_rsp.ack === 1'b1) begin
				rd = od_rsp.rdata;
				ab = od_rsp.abort;
				break;
			end
			@(negedge ref_clk);
		end
	endtask
endmodule // cod_master
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import cod_pkg::*;;
	logic ref_clk = 0, arst_n = 0, clk_en = 1, operational = 0, tx_ready = 1;
	logic fault_active = 0, fault_event = 0;
	logic [31:0] fault_info = 32'h5A5A1234, rdat, grp;
	logic [15:0] raw_long = 16'h1043, raw_trans = 16'h0200, offset_long = 16'h00A8, offset_trans = 16'h0011;
	logic [15:0] nv_cyclic = 16'h0005, nv_evt1 = 16'h0007, nv_evt2 = 16'h0007;
	logic [15:0] nv_preset_x = 16'h0001, nv_preset_y = 16'h0009, nv_app_x = 16'h0002, nv_app_y = 16'h0009;
	logic abrt;
	cod_frame_type rx_frame = '0, tx_frame;
	cod_req_type od_req;
	cod_rsp_type od_rsp;
	logic [15:0] lt_s, tt_s, cyc, px, py;
	logic [31:0] lt_w, tt_w;
	logic [3:0] sgrp, rarm;
	logic [23:0] life;
	logic spulse, alarm, hb_lost;
	int errors = 0, compares = 0, pulses = 0, k;
	logic [15:0] pos_exp [4] = '{16'h1043, 16'hEFBD, 16'h10EB, 16'hF065};
	////////////////////////////////////////////////////////////////////////////////
	always #4 ref_clk = ~ref_clk;
	cod_master m (.ref_clk(ref_clk), .od_req(od_req), .od_rsp(od_rsp));
	cod_core #(.CYC_MS(10)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .od_req(od_req),
		.od_rsp(od_rsp), .rx_frame(rx_frame), .operational(operational), .tx_frame(tx_frame),
		.tx_is_alarm(alarm), .tx_ready(tx_ready), .fault_active(fault_active), .fault_event(fault_event),
		.fault_info(fault_info), .raw_long(raw_long), .raw_trans(raw_trans), .offset_long(offset_long),
		.offset_trans(offset_trans), .longitudinal_tilt_short(lt_s), .transverse_tilt_short(tt_s),
		.longitudinal_tilt_wide(lt_w), .transverse_tilt_wide(tt_w), .nv_cyclic(nv_cyclic),
		.nv_evt1(nv_evt1), .nv_evt2(nv_evt2), .nv_preset_x(nv_preset_x), .nv_preset_y(nv_preset_y),
		.nv_app_x(nv_app_x), .nv_app_y(nv_app_y), .cyclic_interval(cyc), .preset_x(px), .preset_y(py),
		.nv_store_pulse(spulse), .nv_store_group(sgrp), .restore_armed(rarm), .life_time_ms(life),
		.hb_lost(hb_lost));
	// Store pulses are counted here because they last a single cycle.
	always @(posedge ref_clk) begin
		#1;
		if (spulse === 1'b1) begin
			pulses++;
			grp = {28'h0, sgrp};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
		m.acc(w, i, s, d, rdat, abrt);
	endtask
	task automatic rst();
		@(negedge ref_clk);
		arst_n = 0;
		repeat (16) @(negedge ref_clk);
		arst_n = 1;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic close_out();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog sized well beyond the few hundred cycles the sequence needs.
	initial begin
		#200000;
		errors++;
		close_out();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst();
		chk("cyclic", 32'h7, {16'h0, cyc});
		chk("preset", 32'h00020009, {px, py});
		acc(0, IDX_DEVTYPE, 8'h00, 0); chk("devtype", DEVTYPE_DUAL, rdat);
		acc(1, IDX_DEVTYPE, 8'h00, 32'h1); chk("devtype_wr", 1, abrt);
		acc(0, IDX_SYNC, 8'h00, 0); chk("sync_rst", SYNC_RST, rdat);
		acc(0, IDX_ALARM, 8'h00, 0); chk("alarm_rst", ALARM_RST, rdat);
		acc(0, IDX_GUARD, 8'h00, 0); chk("guard_rst", 0, rdat);
		acc(1, IDX_GUARD, 8'h00, 32'h5); acc(1, IDX_LIFE, 8'h00, 32'h3);
		chk("life", 32'd15, {8'h0, life});
		acc(0, 16'h1234, 8'h00, 0); chk("unmapped", 1, abrt);
		// Every option code on the first axis while the second stays plain.
		for (k = 0; k < 4; k++) begin
			acc(1, IDX_OPX, 8'h00, k);
			repeat (2) @(negedge ref_clk);
			chk("tilt_long", {16'h0, pos_exp[k]}, {16'h0, lt_s});
			chk("tilt_wide", {{16{pos_exp[k][15]}}, pos_exp[k]}, lt_w);
			chk("tilt_trans", 32'h0200, {16'h0, tt_s});
		end
		acc(1, IDX_OPY, 8'h00, 32'h2); repeat (2) @(negedge ref_clk);
		chk("tilt_trans_sc", 32'h0211, {16'h0, tt_s});
		chk("tilt_trans_w", 32'h00000211, tt_w);
		// Faults: summary flag, history entry and clearing.
		fault_active = 1; acc(0, IDX_FAULT, 8'h00, 0); chk("fault_bit", 1, rdat & 32'h1);
		fault_event = 1; @(negedge ref_clk); fault_event = 0; fault_active = 0;
		acc(0, IDX_HIST, 8'h00, 0); chk("hist_cnt", 1, rdat);
		acc(0, IDX_HIST, 8'h01, 0); chk("hist_e1", fault_info, rdat);
		acc(1, IDX_HIST, 8'h00, 0); acc(0, IDX_HIST, 8'h00, 0); chk("hist_clr", 0, rdat);
		// Store and restore with right and wrong signatures.
		acc(1, IDX_STORE, 8'h02, SIG_SAVE); chk("store_ab", 0, abrt);
		chk("store_grp", 32'h2, grp);
		acc(1, IDX_STORE, 8'h01, SIG_LOAD); chk("store_bad", 1, abrt);
		chk("pulses", 1, pulses);
		acc(1, IDX_RESTORE, 8'h03, SIG_SAVE); chk("rest_bad", 1, abrt);
		acc(1, IDX_RESTORE, 8'h03, SIG_LOAD); chk("armed", 32'h4, {28'h0, rarm});
		// Sync: a foreign identifier is ignored, the configured one raises a frame.
		@(negedge ref_clk); tx_ready = 0; operational = 1;
		rx_frame = '{1'b1, 11'h085}; @(negedge ref_clk); rx_frame = '0; @(negedge ref_clk);
		chk("no_sync", 0, tx_frame.valid);
		rx_frame = '{1'b1, 11'h080}; @(negedge ref_clk); rx_frame = '0; @(negedge ref_clk);
		chk("sync_tx", 32'h0981, {20'h0, tx_frame});
		fault_event = 1; @(negedge ref_clk); fault_event = 0;
		chk("alarm_first", 32'h1881, {19'h0, alarm, tx_frame});
		tx_ready = 1;
		// Liveness: reserved bits read zero, loss after 3 ms, recovery on the node's frame.
		acc(1, IDX_CONSHB, 8'h01, 32'hFF020003); acc(0, IDX_CONSHB, 8'h01, 0);
		chk("hb_word", 32'h00020003, rdat);
		repeat (60) @(negedge ref_clk); chk("hb_lost", 1, hb_lost);
		rx_frame = '{1'b1, 11'h702}; @(negedge ref_clk); rx_frame = '0; repeat (2) @(negedge ref_clk);
		chk("hb_back", 0, hb_lost);
		// Own heartbeat every 2 ms, held pending while the consumer is busy.
		tx_ready = 0; acc(1, IDX_PRODHB, 8'h00, 32'h2); repeat (30) @(negedge ref_clk);
		chk("hb_tx", 32'h0F01, {20'h0, tx_frame});
		tx_ready = 1;
		// Armed restore groups do not survive the power cycle.
		rst(); chk("armed_rst", 0, {28'h0, rarm});
		close_out();
	end
endmodule // tb
`default_nettype wire
